// ### rtl/scr_pkg.sv
/*
  Shared constants, command table and state types of the serial command
  responder. Assumes a single 40 MHz system clock.
*/
package scr_pkg;

  localparam int CLK_HZ = 40000000;
  localparam int BAUD_RATE = 115200;
  localparam int BIT_CYC = CLK_HZ / BAUD_RATE;
  localparam int LINE_MAX = 32;
  localparam int WARM_US = 1000;
  localparam int WARM_CYC = WARM_US * (CLK_HZ / 1000000);
  localparam int PW = 28;
  localparam int NCMD = 17;

  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_Q = 8'h3f;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UZ = 8'h5a;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7a;
  localparam logic [7:0] CH_CASE = 8'h20;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_5 = 8'h35;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_M = 8'h4d;

  localparam logic [95:0] MSG_ERR = "Syntax error";
  localparam logic [15:0] MSG_OK = "OK";
  localparam logic [3:0] ERR_LEN = 4'hc;
  localparam logic [3:0] OK_LEN = 4'h2;
  localparam logic [3:0] NUM_LEN = 4'h1;

  localparam logic [1:0] RM_CP = 2'h0;
  localparam logic [1:0] RM_CC = 2'h1;
  localparam logic [1:0] RM_PM = 2'h2;
  localparam logic [1:0] RM_CM = 2'h3;

  localparam logic [1:0] F_BARE = 2'h0;
  localparam logic [1:0] F_QUERY = 2'h1;
  localparam logic [1:0] F_SET = 2'h2;

  localparam logic [1:0] A_OK = 2'h0;
  localparam logic [1:0] A_ERR = 2'h1;
  localparam logic [1:0] A_NUM = 2'h2;

  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_INTERLOCK = 2'h1;
  localparam logic [1:0] FLT_EXTERNAL = 2'h2;

  localparam logic [2:0] ST_OFF = 3'h0;
  localparam logic [2:0] ST_WARM = 3'h1;
  localparam logic [2:0] ST_ON = 3'h2;
  localparam logic [2:0] ST_FAULT = 3'h3;
  localparam logic [2:0] ST_ABORT = 3'h4;

  localparam logic [4:0] CMD_STAT = 5'h00;
  localparam logic [4:0] CMD_FAUL = 5'h01;
  localparam logic [4:0] CMD_FCLR = 5'h02;
  localparam logic [4:0] CMD_STAR = 5'h03;
  localparam logic [4:0] CMD_STOP = 5'h04;
  localparam logic [4:0] CMD_REST = 5'h05;
  localparam logic [4:0] CMD_ABOR = 5'h06;
  localparam logic [4:0] CMD_PAUS = 5'h07;
  localparam logic [4:0] CMD_IMP = 5'h0c;
  localparam logic [4:0] CMD_RUNM = 5'h0d;
  localparam logic [4:0] CMD_RANG = 5'h0e;
  localparam logic [4:0] CMD_KEY = 5'h0f;
  localparam logic [4:0] CMD_LED = 5'h10;

  localparam int FLAG_PAUSE = 0;
  localparam int FLAG_PMDIG = 1;
  localparam int FLAG_PMANA = 2;
  localparam int FLAG_CMDIG = 3;
  localparam int FLAG_CMANA = 4;
  localparam int FLAG_IMP = 5;
  localparam logic [5:0] FLAGS_RST = 6'h20;
  localparam logic VRANGE_RST = 1'b1;

  typedef enum logic [3:0] {
    P_RECV = 4'b0001,
    P_MATCH = 4'b0010,
    P_EXEC = 4'b0100,
    P_SEND = 4'b1000
  } scr_pst_e;

  typedef enum logic [4:0] {
    L_OFF = 5'b00001,
    L_WARM = 5'b00010,
    L_ON = 5'b00100,
    L_FAULT = 5'b01000,
    L_ABORT = 5'b10000
  } scr_lst_e;

  // Keywords hold only the abbreviated capitals; longer spellings are
  // accepted by the matcher skipping extra letters of each segment.
  function automatic logic [8*PW-1:0] cmd_pat(input int c);
    case (c)
      0: return "STAT";
      1: return "FAUL";
      2: return "FAUL:CLE";
      3: return "STAR";
      4: return "STOP";
      5: return "AUTO:REST";
      6: return "AUTO:ABOR";
      7: return "LAS:PAUS";
      8: return "LAS:PM:DIG:ENA";
      9: return "LAS:PM:ANA:ENA";
      10: return "LAS:CM:DIG:ENA";
      11: return "LAS:CM:ANA:ENA";
      12: return "SYST:INP:ANA:IMP";
      13: return "LAS:RUNM";
      14: return "SYST:INP:ANA:VOLT:RANG:MAX";
      15: return "KEY:ENA";
      16: return "LED";
      default: return '0;
    endcase
  endfunction

  function automatic int cmd_len(input int c);
    logic [8*PW-1:0] p;
    int n;
    p = cmd_pat(c);
    n = 0;
    for (int i = 0; i < PW; i++)
    begin
      if (p[8*i +: 8] != 8'h00)
        n++;
    end
    return n;
  endfunction

  function automatic logic [7:0] cmd_char(input int c, input int i);
    logic [8*PW-1:0] p;
    int n;
    p = cmd_pat(c);
    n = cmd_len(c);
    if (i >= n)
      return 8'h00;
    return p[8*(n-1-i) +: 8];
  endfunction

endpackage

// ### rtl/scr_uart_rx.sv
/*
  Asynchronous serial receiver, 8 data bits, no parity, 1 stop bit.
  Assumes rxd is already synchronous to clk and idles high.
*/
`timescale 1ns/100ps
`default_nettype none
module scr_uart_rx
  import scr_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rxd,
  output logic [7:0] data,
  output logic valid
);

  localparam int CW = $clog2(BIT_CYC_P);

  logic busy_r;
  logic [CW-1:0] cnt_r;
  logic [3:0] nbit_r;
  logic [7:0] sh_r;
  wire tick = busy_r && cnt_r == CW'(BIT_CYC_P - 1);

  // The counter starts half a bit in, so every sample lands mid-bit.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      nbit_r <= 4'h0;
      sh_r <= 8'h00;
      data <= 8'h00;
      valid <= 1'b0;
    end
    else
    begin
      valid <= 1'b0;
      if (!busy_r)
      begin
        busy_r <= !rxd;
        cnt_r <= CW'(BIT_CYC_P / 2);
        nbit_r <= 4'h0;
      end
      else if (tick)
      begin
        cnt_r <= '0;
        nbit_r <= nbit_r + 4'h1;
        if (nbit_r == 4'h0 && rxd)
          busy_r <= 1'b0;
        else if (nbit_r == 4'h9)
        begin
          busy_r <= 1'b0;
          valid <= rxd;
          data <= sh_r;
        end
        else if (nbit_r != 4'h0)
          sh_r <= {rxd, sh_r[7:1]};
      end
      else
        cnt_r <= cnt_r + CW'(1);
    end
  end

endmodule
`default_nettype wire

// ### rtl/scr_uart_tx.sv
/*
  Asynchronous serial transmitter, 8 data bits, no parity, 1 stop bit.
  Assumes start is raised only while ready is high.
*/
`timescale 1ns/100ps
`default_nettype none
module scr_uart_tx
  import scr_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] data,
  output logic ready,
  output logic txd
);

  localparam int CW = $clog2(BIT_CYC_P);

  logic busy_r;
  logic [CW-1:0] cnt_r;
  logic [3:0] nbit_r;
  logic [8:0] sh_r;
  wire tick = busy_r && cnt_r == CW'(BIT_CYC_P - 1);

  assign ready = !busy_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      nbit_r <= 4'h0;
      sh_r <= 9'h1ff;
      txd <= 1'b1;
    end
    else if (!busy_r)
    begin
      if (start)
      begin
        busy_r <= 1'b1;
        cnt_r <= '0;
        nbit_r <= 4'h9;
        sh_r <= {1'b1, data};
        txd <= 1'b0;
      end
    end
    else if (tick)
    begin
      cnt_r <= '0;
      if (nbit_r == 4'h0)
        busy_r <= 1'b0;
      else
      begin
        txd <= sh_r[0];
        sh_r <= {1'b1, sh_r[8:1]};
        nbit_r <= nbit_r - 4'h1;
      end
    end
    else
      cnt_r <= cnt_r + CW'(1);
  end

endmodule
`default_nettype wire

// ### rtl/scr_responder.sv
/*
  Text command responder of a laser controller: line receiver, keyword
  matcher, command execution, answer sender and the laser state machine.
  Assumes synchronous level inputs and one 40 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module scr_responder
  import scr_pkg::*;
#(
  parameter int LINE_MAX_P = LINE_MAX,
  parameter int WARM_CYC_P = WARM_CYC,
  parameter int BIT_CYC_P = BIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rxd,
  output logic txd,
  input wire logic autostart_en,
  input wire logic key_switch_configuration,
  input wire logic key_on,
  input wire logic interlock_closed,
  input wire logic fault_in,
  output logic emission_en,
  output logic laser_armed,
  output logic [1:0] run_mode,
  output logic mod_digital_en,
  output logic mod_analog_en,
  output logic power_loop_en,
  output logic ana_imp_high,
  output logic ana_range_5v,
  output logic led_power,
  output logic led_on,
  output logic led_error
);

  localparam int AW = $clog2(LINE_MAX_P);
  localparam int LW = $clog2(LINE_MAX_P + 1);
  localparam int WW = $clog2(WARM_CYC_P + 1);

  logic [7:0] rx_data;
  logic rx_valid;
  logic tx_ready;
  logic tx_start;
  logic [7:0] tx_char;
  scr_pst_e pst_r;
  scr_pst_e pst_nxt;
  scr_lst_e lst_r;
  scr_lst_e lst_nxt;
  logic [7:0] buf_r [LINE_MAX_P];
  logic [LW-1:0] len_r;
  logic [LW-1:0] b_r;
  logic [4:0] c_r;
  logic [4:0] p_r;
  logic ovf_r;
  logic hit_r;
  logic [1:0] form_r;
  logic [1:0] ans_kind_r;
  logic [7:0] ans_ch_r;
  logic [3:0] k_r;
  logic [5:0] flags_r;
  logic [1:0] mode_r;
  logic vrange_r;
  logic [1:0] fault_r;
  logic key_prev_r;
  logic [WW-1:0] warm_r;
  logic ans_ok;
  logic ans_num;
  logic [7:0] num_ch;
  logic clr_req;
  logic on_req;
  logic off_req;
  logic rst_req;
  logic abort_req;
  logic flag_wr;
  logic mode_wr;
  logic rng_wr;
  logic [2:0] st_code;

  scr_uart_rx #(.BIT_CYC_P(BIT_CYC_P)) u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .rxd(rxd),
    .data(rx_data),
    .valid(rx_valid)
  );

  scr_uart_tx #(.BIT_CYC_P(BIT_CYC_P)) u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .start(tx_start),
    .data(tx_char),
    .ready(tx_ready),
    .txd(txd)
  );

  // Line receiver. Characters arriving outside P_RECV are dropped, so the
  // host must wait for each answer before sending the next line.
  wire rx_cr = rx_valid && rx_data == CH_CR;
  wire rx_room = len_r < LW'(LINE_MAX_P);
  wire rx_store = pst_r == P_RECV && rx_valid && !rx_cr && rx_room;
  wire rx_low = rx_data >= CH_LA && rx_data <= CH_LZ;
  wire [7:0] rx_up = rx_low ? rx_data - CH_CASE : rx_data;

  always_ff @(posedge clk)
  begin
    if (rx_store)
      buf_r[len_r[AW-1:0]] <= rx_up;
  end

  // Matcher walks one character per cycle through each keyword in turn.
  wire [7:0] pc = cmd_char(int'(c_r), int'(p_r));
  wire pend = int'(p_r) >= cmd_len(int'(c_r));
  wire at_end = b_r >= len_r;
  wire [7:0] bc = at_end ? 8'h00 : buf_r[b_r[AW-1:0]];
  wire bc_let = bc >= CH_UA && bc <= CH_UZ;
  wire [LW-1:0] b1 = b_r + LW'(1);
  wire [LW-1:0] b2 = b_r + LW'(2);
  wire last1 = b1 == len_r;
  wire last_cmd = c_r == 5'(NCMD - 1);
  wire m_adv = !pend && !at_end && pc == bc;
  wire m_skip = !m_adv && (pend || pc == CH_COLON) && !at_end && bc_let;
  wire f_query = bc == CH_Q && last1;
  wire f_set = bc == CH_SP && !last1 && !at_end;
  wire m_hit = pend && !m_skip && (at_end || f_query || f_set);
  wire m_fail = !m_adv && !m_skip && !m_hit;
  wire m_empty = ovf_r || len_r == '0;

  // Argument fields of a set command.
  wire [7:0] a0 = (b1 < len_r) ? buf_r[b1[AW-1:0]] : 8'h00;
  wire [7:0] a1 = (b2 < len_r) ? buf_r[b2[AW-1:0]] : 8'h00;
  wire [LW-1:0] alen = len_r - b1;
  wire a_one = alen == LW'(1);
  wire a_two = alen == LW'(2);
  wire a_bit = a_one && (a0 == CH_0 || a0 == CH_1);
  wire [2:0] fidx = 3'(c_r - CMD_PAUS);
  wire is_flag = c_r >= CMD_PAUS && c_r <= CMD_IMP;
  wire md_cp = a_two && a0 == CH_C && a1 == CH_P;
  wire md_cc = a_two && a0 == CH_C && a1 == CH_C;
  wire md_pm = a_two && a0 == CH_P && a1 == CH_M;
  wire md_cm = a_two && a0 == CH_C && a1 == CH_M;
  wire md_ok = md_cp || md_cc || md_pm || md_cm;
  wire [1:0] md_arg = md_cc ? RM_CC : md_pm ? RM_PM : md_cm ? RM_CM : RM_CP;
  wire rng_ok = a_one && (a0 == CH_1 || a0 == CH_5);
  wire ex = pst_r == P_EXEC && hit_r;
  wire fq = form_r == F_QUERY;
  wire fs = form_r == F_SET;
  wire fb = form_r == F_BARE;
  wire [2:0] led_bits = {led_error, led_on, led_power};

  always_comb
  begin
    ans_ok = 1'b0;
    ans_num = 1'b0;
    num_ch = CH_0;
    clr_req = 1'b0;
    on_req = 1'b0;
    off_req = 1'b0;
    rst_req = 1'b0;
    abort_req = 1'b0;
    flag_wr = 1'b0;
    mode_wr = 1'b0;
    rng_wr = 1'b0;
    if (ex)
    begin
      case (c_r)
        CMD_STAT:
        begin
          ans_num = fq;
          num_ch = CH_0 + {5'h00, st_code};
        end
        CMD_FAUL:
        begin
          ans_num = fq;
          num_ch = CH_0 + {6'h00, fault_r};
        end
        CMD_FCLR:
        begin
          clr_req = fb;
          ans_ok = fb;
        end
        CMD_STAR:
        begin
          on_req = fb;
          ans_ok = fb;
        end
        CMD_STOP:
        begin
          off_req = fb;
          ans_ok = fb;
        end
        CMD_REST:
        begin
          rst_req = fb;
          ans_ok = fb;
        end
        CMD_ABOR:
        begin
          abort_req = fb;
          ans_ok = fb;
        end
        CMD_RUNM:
        begin
          ans_num = fq;
          num_ch = CH_0 + {6'h00, mode_r};
          mode_wr = fs && md_ok;
          ans_ok = mode_wr;
        end
        CMD_RANG:
        begin
          ans_num = fq;
          num_ch = vrange_r ? CH_5 : CH_1;
          rng_wr = fs && rng_ok;
          ans_ok = rng_wr;
        end
        CMD_KEY:
        begin
          ans_num = fq;
          num_ch = CH_0 + {7'h00, key_switch_configuration};
        end
        CMD_LED:
        begin
          ans_num = fq;
          num_ch = CH_0 + {5'h00, led_bits};
        end
        default:
        begin
          ans_num = is_flag && fq;
          num_ch = CH_0 + {7'h00, flags_r[fidx]};
          flag_wr = is_flag && fs && a_bit;
          ans_ok = flag_wr;
        end
      endcase
    end
  end

  // Answer sender: payload then carriage return.
  wire [3:0] ans_len = ans_kind_r == A_OK ? OK_LEN :
                       ans_kind_r == A_NUM ? NUM_LEN : ERR_LEN;
  wire k_end = k_r >= ans_len;
  wire [7:0] ch_ok = MSG_OK[8*(int'(OK_LEN) - 1 - int'(k_r[0])) +: 8];
  wire [7:0] ch_err = MSG_ERR[8*(int'(ERR_LEN) - 1 - int'(k_r)) +: 8];
  wire [7:0] ch_body = ans_kind_r == A_OK ? ch_ok :
                       ans_kind_r == A_NUM ? ans_ch_r : ch_err;
  assign tx_char = k_end ? CH_CR : ch_body;
  assign tx_start = pst_r == P_SEND && tx_ready;

  always_comb
  begin
    case (pst_r)
      P_RECV: pst_nxt = rx_cr ? P_MATCH : P_RECV;
      P_MATCH: pst_nxt = (m_empty || m_hit || (m_fail && last_cmd)) ?
                         P_EXEC : P_MATCH;
      P_EXEC: pst_nxt = P_SEND;
      P_SEND: pst_nxt = (tx_start && k_end) ? P_RECV : P_SEND;
      default: pst_nxt = P_RECV;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pst_r <= P_RECV;
      len_r <= '0;
      b_r <= '0;
      c_r <= 5'h00;
      p_r <= 5'h00;
      ovf_r <= 1'b0;
      hit_r <= 1'b0;
      form_r <= F_BARE;
      ans_kind_r <= A_ERR;
      ans_ch_r <= CH_0;
      k_r <= 4'h0;
    end
    else
    begin
      pst_r <= pst_nxt;
      case (pst_r)
        P_RECV:
        begin
          c_r <= 5'h00;
          p_r <= 5'h00;
          b_r <= '0;
          hit_r <= 1'b0;
          if (rx_valid && !rx_cr)
          begin
            if (rx_room)
              len_r <= len_r + LW'(1);
            else
              ovf_r <= 1'b1;
          end
        end
        P_MATCH:
        begin
          if (m_empty)
            hit_r <= 1'b0;
          else if (m_adv || m_skip)
          begin
            b_r <= b1;
            p_r <= m_adv ? p_r + 5'h01 : p_r;
          end
          else if (m_hit)
          begin
            hit_r <= 1'b1;
            form_r <= at_end ? F_BARE : f_query ? F_QUERY : F_SET;
          end
          else
          begin
            c_r <= c_r + 5'h01;
            p_r <= 5'h00;
            b_r <= '0;
          end
        end
        P_EXEC:
        begin
          ans_kind_r <= ans_num ? A_NUM : ans_ok ? A_OK : A_ERR;
          ans_ch_r <= num_ch;
          k_r <= 4'h0;
        end
        P_SEND:
        begin
          if (tx_start)
          begin
            k_r <= k_r + 4'h1;
            if (k_end)
            begin
              len_r <= '0;
              ovf_r <= 1'b0;
            end
          end
        end
        default: hit_r <= 1'b0;
      endcase
    end
  end

  // Laser state machine.
  wire err_evt = !interlock_closed || fault_in;
  wire key_rise = key_switch_configuration && key_on && !key_prev_r;
  wire key_ok = !key_switch_configuration || key_on;
  wire key_drop = key_switch_configuration && !key_on;
  wire warm_done = warm_r == WW'(WARM_CYC_P - 1);
  wire is_fault = lst_r == L_FAULT;
  scr_lst_e start_tgt;
  assign start_tgt = autostart_en ? L_WARM : L_ON;

  always_comb
  begin
    lst_nxt = lst_r;
    case (lst_r)
      L_OFF, L_ABORT:
      begin
        if (key_rise || (rst_req && key_ok))
          lst_nxt = L_WARM;
        else if (on_req && key_ok)
          lst_nxt = start_tgt;
      end
      L_WARM:
      begin
        if (abort_req)
          lst_nxt = L_ABORT;
        else if (off_req || key_drop)
          lst_nxt = L_OFF;
        else if (warm_done)
          lst_nxt = L_ON;
      end
      L_ON:
      begin
        if (abort_req)
          lst_nxt = L_ABORT;
        else if (off_req || key_drop)
          lst_nxt = L_OFF;
        else if (rst_req || (on_req && autostart_en))
          lst_nxt = L_WARM;
      end
      L_FAULT:
      begin
        if (key_rise)
          lst_nxt = L_WARM;
        else if (clr_req)
          lst_nxt = L_OFF;
      end
      default: lst_nxt = L_OFF;
    endcase
    if (err_evt)
      lst_nxt = L_FAULT;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lst_r <= L_OFF;
      fault_r <= FLT_NONE;
      // Reset high so a key already on at power-up is not taken as a turn.
      key_prev_r <= 1'b1;
      warm_r <= '0;
      flags_r <= FLAGS_RST;
      mode_r <= RM_CP;
      vrange_r <= VRANGE_RST;
    end
    else
    begin
      lst_r <= lst_nxt;
      key_prev_r <= key_on;
      warm_r <= (lst_r != L_WARM || rst_req) ? '0 : warm_r + WW'(1);
      if (err_evt)
        fault_r <= interlock_closed ? FLT_EXTERNAL : FLT_INTERLOCK;
      else if (is_fault && (clr_req || key_rise))
        fault_r <= FLT_NONE;
      if (flag_wr)
        flags_r[fidx] <= a0 == CH_1;
      if (mode_wr)
        mode_r <= md_arg;
      if (rng_wr)
        vrange_r <= a0 == CH_5;
    end
  end

  assign st_code = lst_r == L_WARM ? ST_WARM :
                   lst_r == L_ON ? ST_ON :
                   lst_r == L_FAULT ? ST_FAULT :
                   lst_r == L_ABORT ? ST_ABORT : ST_OFF;

  wire md_is_pm = mode_r == RM_PM;
  wire md_is_cm = mode_r == RM_CM;
  assign laser_armed = lst_r == L_ON;
  assign emission_en = laser_armed && !flags_r[FLAG_PAUSE];
  assign run_mode = mode_r;
  assign mod_digital_en = (md_is_pm && flags_r[FLAG_PMDIG]) ||
                          (md_is_cm && flags_r[FLAG_CMDIG]);
  assign mod_analog_en = (md_is_pm && flags_r[FLAG_PMANA]) ||
                         (md_is_cm && flags_r[FLAG_CMANA]);
  // The current loop itself lives outside; this only selects power control.
  assign power_loop_en = laser_armed && (mode_r == RM_CP || md_is_pm);
  assign ana_imp_high = flags_r[FLAG_IMP];
  assign ana_range_5v = vrange_r;
  assign led_power = 1'b1;
  assign led_on = laser_armed;
  assign led_error = fault_r != FLT_NONE;

endmodule
`default_nettype wire

// ### test/scr_responder_asserts.sv
/*
  Checker for the laser state and lamp outputs of the responder.
  Assumes it is bound to the responder top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module scr_responder_asserts
  import scr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interlock_closed,
  input wire logic fault_in,
  input wire logic emission_en,
  input wire logic laser_armed,
  input wire logic [1:0] run_mode,
  input wire logic mod_digital_en,
  input wire logic mod_analog_en,
  input wire logic power_loop_en,
  input wire logic led_power,
  input wire logic led_on,
  input wire logic led_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  power_lamp_a: assert property (led_power)
    else $error("power lamp dark");
  on_lamp_a: assert property (led_on == laser_armed)
    else $error("on lamp differs from armed");
  pause_armed_a: assert property (emission_en |-> laser_armed)
    else $error("emission while not armed");
  power_loop_a: assert property (power_loop_en == (laser_armed &&
    (run_mode == RM_CP || run_mode == RM_PM)))
    else $error("power loop enable wrong");
  mod_off_a: assert property (!run_mode[1] |->
    !mod_digital_en && !mod_analog_en)
    else $error("modulation enabled in constant mode");
  interlock_stop_a: assert property (!interlock_closed |=>
    led_error && !laser_armed)
    else $error("open loop did not stop the laser");
  fault_stop_a: assert property (fault_in |=> !emission_en && led_error)
    else $error("error event did not stop emission");
  clear_off_a: assert property ($fell(led_error) |-> !laser_armed)
    else $error("clearing the fault armed the laser");
endmodule
`default_nettype wire

// ### test/scr_host_model.sv
/*
  Host computer on the serial link: sends text lines, collects answers.
  Assumes 8N1 framing at the bit time given by the parameter.
*/
`timescale 1ns/100ps
`default_nettype none
module scr_host_model
  import scr_pkg::*;
#(
  parameter int BIT_CYC_P = 8
) (
  input wire logic clk,
  output logic rxd,
  input wire logic txd
);
  string got = "";
  string cur = "";
  int n_ans = 0;
  initial rxd = 1'b1;
  // One link only, LSB first, idle and stop high.
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd = f[i];
      repeat (BIT_CYC_P) @(negedge clk);
    end
  endtask
  // Callers put exactly one space before an argument.
  task automatic line(input string s);
    for (int i = 0; i < s.len(); i++)
      put(s[i]);
    put(CH_CR);
  endtask
  initial
  begin
    logic [7:0] c;
    forever
    begin
      @(negedge txd);
      repeat (BIT_CYC_P / 2) @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT_CYC_P) @(posedge clk);
        if (i < 8)
          c[i] = txd;
      end
      if (c == CH_CR)
      begin
        got = cur;
        cur = "";
        n_ans++;
      end
      else
        cur = {cur, string'(c)};
    end
  end
endmodule
`default_nettype wire

// ### test/scr_responder_tb.sv
/*
  Bench for the responder: command lines through the host model.
  Assumes an 8-clock bit time and a shortened warm-up.
*/
`timescale 1ns/100ps
`default_nettype none
module scr_responder_tb
  import scr_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rxd, txd, autostart_en, key_switch_configuration, key_on;
  logic interlock_closed, fault_in, emission_en, laser_armed;
  logic mod_digital_en, mod_analog_en, power_loop_en, ana_imp_high;
  logic ana_range_5v, led_power, led_on, led_error;
  logic [1:0] run_mode;
  int fails = 0;
  int checks = 0;
  initial forever #12.5 clk = ~clk;
  scr_host_model #(.BIT_CYC_P(8)) u_scr_host_model (.clk, .rxd, .txd);
  scr_responder #(.WARM_CYC_P(2000), .BIT_CYC_P(8)) u_scr_responder (
    .clk, .rst_n, .rxd, .txd, .autostart_en, .key_switch_configuration,
    .key_on, .interlock_closed, .fault_in, .emission_en, .laser_armed,
    .run_mode, .mod_digital_en, .mod_analog_en, .power_loop_en,
    .ana_imp_high, .ana_range_5v, .led_power, .led_on, .led_error);
  task automatic cmp_v(input logic [3:0] g, input logic [3:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_s(input string g, input string e);
    checks++;
    if (g != e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Waiting for the answer keeps one line in flight at a time.
  task automatic cmd(input string s, input string e);
    int n;
    n = u_scr_host_model.n_ans;
    u_scr_host_model.line(s);
    for (int i = 0; i < 3000 && u_scr_host_model.n_ans == n; i++)
      @(negedge clk);
    repeat (8) @(negedge clk);
    cmp_v(4'(u_scr_host_model.n_ans - n), 4'h1);
    cmp_s(u_scr_host_model.got, e);
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge clk);
    fails++;
    give_verdict;
  end
  initial
  begin
    string m[4] = '{"cp", "Cc", "pM", "CM"};
    int n0;
    autostart_en = 1'b0;
    key_switch_configuration = 1'b0;
    key_on = 1'b0;
    interlock_closed = 1'b1;
    fault_in = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    cmp_v({ana_imp_high, ana_range_5v, run_mode}, 4'hc);
    cmd("STAT?", "0");
    cmd("bogus", "Syntax error");
    for (int i = 0; i < 4; i++)
    begin
      cmd({"las:runm ", m[i]}, "OK");
      cmp_v(run_mode, i[3:0]);
    end
    cmd("LASER:RUNMODE?", "3");
    cmd("LAS:CM:DIG:ENA 1", "OK");
    cmp_v({mod_digital_en, mod_analog_en}, 4'h2);
    cmd("LAS:RUNM CP", "OK");
    cmd("syst:inp:ana:imp 0", "OK");
    cmd("SYST:INP:ANA:VOLT:RANG:MAX 1", "OK");
    cmp_v({ana_imp_high, ana_range_5v, mod_digital_en}, 4'h0);
    cmd("KEY:ENA?", "0");
    cmd("STAR", "OK");
    cmp_v({laser_armed, emission_en, power_loop_en}, 4'h7);
    cmd("LAS:PAUS 1", "OK");
    cmp_v({laser_armed, emission_en}, 4'h2);
    cmd("STAT?", "2");
    cmd("LED?", "3");
    interlock_closed = 1'b0;
    repeat (3) @(negedge clk);
    interlock_closed = 1'b1;
    cmd("FAUL?", "1");
    cmd("LED?", "5");
    cmd("FAUL:CLE", "OK");
    cmp_v({laser_armed, led_error}, 4'h0);
    cmd("STAR", "OK");
    cmp_v(laser_armed, 4'h1);
    key_on = 1'b1;
    key_switch_configuration = 1'b1;
    fault_in = 1'b1;
    @(negedge clk);
    fault_in = 1'b0;
    cmd("FAUL?", "2");
    key_on = 1'b0;
    @(negedge clk);
    key_on = 1'b1;
    cmd("STAT?", "1");
    repeat (2000) @(negedge clk);
    cmd("STAT?", "2");
    autostart_en = 1'b1;
    cmd("STAR", "OK");
    cmd("STAT?", "1");
    cmd("AAAAAAAAAAAAAAAAAAAAAAAAAAAAAAAAA", "Syntax error");
    cmd("STAT?", "2");
    cmd("AUTO:ABOR", "OK");
    cmd("STAT?", "4");
    cmd("AUTO:REST", "OK");
    cmd("STAT?", "1");
    cmd("STOP", "OK");
    cmd("STAT?", "0");
    cmd("KEY:ENA?", "1");
    cmd("", "Syntax error");
    cmd("STOP 1", "Syntax error");
    cmd("LAS:RUNM PM", "OK");
    cmd("las:pm:ana:ena 1", "OK");
    cmp_v({mod_digital_en, mod_analog_en}, 4'h1);
    cmd("SYST:INP:ANA:VOLT:RANG:MAX?", "1");
    n0 = u_scr_host_model.n_ans;
    repeat (600) @(negedge clk);
    cmp_v(4'(u_scr_host_model.n_ans - n0), 4'h0);
    give_verdict;
  end
endmodule
bind scr_responder scr_responder_asserts u_scr_responder_asserts (
  .clk, .rst_n, .interlock_closed, .fault_in, .emission_en, .laser_armed,
  .run_mode, .mod_digital_en, .mod_analog_en, .power_loop_en,
  .led_power, .led_on, .led_error);
`default_nettype wire
